// ===== logic/vdm_pkg.sv
// constants, frame layout and decode helpers for the valve driver message block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package vdm_pkg;

   localparam int          NUM_DRV    = 3;
   localparam int          PAY_W      = 10;
   localparam int          ADC_W      = 10;
   localparam int          FRAME_W    = 16;
   localparam logic [4:0]  FRAME_BITS = 5'h10;
   localparam logic [4:0]  CNT_MAX    = 5'h1F;

   // message identifiers
   localparam logic [4:0]  ID_NONE    = 5'h00;
   localparam logic [4:0]  ID_DRV2    = 5'h0B;
   localparam logic [4:0]  ID_DRV3    = 5'h0C;
   localparam logic [4:0]  ID_DRV4    = 5'h0D;
   localparam logic [4:0]  ID_ADC1    = 5'h0E;

   // odd parity over all sixteen bits
   localparam logic        PARITY_ODD = 1'h1;

   // reset values
   localparam logic [PAY_W-1:0] PAYLOAD_RST = 10'h000;
   localparam logic             FMSG_RST    = 1'h0;

   typedef struct packed {
      logic overcurrent;
      logic open_load;
      logic overtemp;
      logic drain_voltage_flag;
   } vdm_status_t;

   typedef struct packed {
      logic [7:0]       duty_applied;
      logic [ADC_W-1:0] current;
   } vdm_meas_t;

   typedef struct packed {
      logic             parity;
      logic             fmsg;
      vdm_status_t      flags;
      logic [PAY_W-1:0] data;
   } vdm_frame_t;

   typedef struct packed {
      logic       hit;
      logic [1:0] idx;
   } vdm_sel_t;

   function automatic vdm_sel_t drv_slot(input logic [4:0] id);
      vdm_sel_t s;
      s.hit = 1'h1;
      case (id)
         ID_DRV2: s.idx = 2'h0;
         ID_DRV3: s.idx = 2'h1;
         ID_DRV4: s.idx = 2'h2;
         default: begin
            s.hit = 1'h0;
            s.idx = 2'h0;
         end
      endcase
      return s;
   endfunction : drv_slot

   function automatic logic parity_ok(input logic [FRAME_W-1:0] w);
      return (^w) == PARITY_ODD;
   endfunction : parity_ok

endpackage : vdm_pkg

// ===== logic/vdm_readback.sv
// readback field selection for one valve driver
module vdm_readback
   import vdm_pkg::*;
(
   input  wire logic             i_reg_disable,
   input  wire logic             i_feedback_select,
   input  wire logic [PAY_W-1:0] i_payload,
   input  wire logic [7:0]       i_duty_applied,
   input  wire logic [ADC_W-1:0] i_current,
   output logic      [PAY_W-1:0] o_field
);

   always_comb begin
      case ({i_reg_disable, i_feedback_select})
         2'h0:    o_field = i_payload;
         2'h1:    o_field = {i_duty_applied, 2'h0};
         2'h2:    o_field = {i_payload[PAY_W-1:2], 2'h0};
         2'h3:    o_field = i_current;
         default: o_field = '0;
      endcase
   end

endmodule : vdm_readback

// ===== logic/vdm_spi_shift.sv
// sixteen bit serial frame shifter, sampled on the system clock
module vdm_spi_shift
   import vdm_pkg::*;
(
   input  wire logic               i_mclk,
   input  wire logic               i_rst,
   input  wire logic               i_cs_n,
   input  wire logic               i_sclk,
   input  wire logic               i_mosi,
   input  wire logic [FRAME_W-1:0] i_tx_word,
   output logic                    o_miso,
   output logic                    o_miso_oe,
   output logic      [FRAME_W-1:0] o_rx_word,
   output logic                    o_rx_done,
   output logic                    o_rx_len_ok
);

   typedef enum logic [1:0] {
      SPI_IDLE  = 2'h0,
      SPI_SHIFT = 2'h1,
      SPI_DONE  = 2'h3
   } vdm_spi_state_t;

   vdm_spi_state_t     state_ff, nxt_state;
   logic [FRAME_W-1:0] tx_ff, nxt_tx;
   logic [FRAME_W-1:0] rx_ff, nxt_rx;
   logic [4:0]         cnt_ff, nxt_cnt;
   logic               oe_ff, nxt_oe;
   logic               done_ff, nxt_done;
   logic               len_ok_ff, nxt_len_ok;
   logic               sclk_ff;
   logic               sclk_rise;
   logic               sclk_fall;

   assign sclk_rise = i_sclk & ~sclk_ff;
   assign sclk_fall = ~i_sclk & sclk_ff;

   always_comb begin
      nxt_state  = state_ff;
      nxt_tx     = tx_ff;
      nxt_rx     = rx_ff;
      nxt_cnt    = cnt_ff;
      nxt_oe     = oe_ff;
      nxt_done   = 1'h0;
      nxt_len_ok = len_ok_ff;
      case (state_ff)
         SPI_IDLE: begin
            // reply is frozen at select so a late update cannot tear it
            if (!i_cs_n) begin
               nxt_state = SPI_SHIFT;
               nxt_tx    = i_tx_word;
               nxt_cnt   = '0;
               nxt_oe    = 1'h1;
            end
         end
         SPI_SHIFT: begin
            if (i_cs_n) begin
               nxt_state  = SPI_DONE;
               nxt_oe     = 1'h0;
               nxt_done   = 1'h1;
               nxt_len_ok = (cnt_ff == FRAME_BITS);
            end else begin
               if (sclk_rise) begin
                  nxt_rx = {rx_ff[FRAME_W-2:0], i_mosi};
                  if (cnt_ff != CNT_MAX) begin
                     nxt_cnt = cnt_ff + 5'h01;
                  end
               end
               // hold msb through the first rising edge
               if (sclk_fall && cnt_ff != 5'h00) begin
                  nxt_tx = {tx_ff[FRAME_W-2:0], 1'h0};
               end
            end
         end
         SPI_DONE: nxt_state = SPI_IDLE;
         default:  nxt_state = SPI_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_ff  <= SPI_IDLE;
         tx_ff     <= '0;
         rx_ff     <= '0;
         cnt_ff    <= '0;
         oe_ff     <= 1'h0;
         done_ff   <= 1'h0;
         len_ok_ff <= 1'h0;
         sclk_ff   <= 1'h0;
      end else begin
         state_ff  <= nxt_state;
         tx_ff     <= nxt_tx;
         rx_ff     <= nxt_rx;
         cnt_ff    <= nxt_cnt;
         oe_ff     <= nxt_oe;
         done_ff   <= nxt_done;
         len_ok_ff <= nxt_len_ok;
         sclk_ff   <= i_sclk;
      end
   end

   assign o_miso      = tx_ff[FRAME_W-1];
   assign o_miso_oe   = oe_ff;
   assign o_rx_word   = rx_ff;
   assign o_rx_done   = done_ff;
   assign o_rx_len_ok = len_ok_ff;

endmodule : vdm_spi_shift

// ===== logic/vdm_top.sv
// message decode and reply for valve drivers two to four and analog input one
module vdm_top
   import vdm_pkg::*;
(
   input  wire logic                            i_mclk,
   input  wire logic                            i_rst,
   input  wire logic                            i_cs_n,
   input  wire logic                            i_sclk,
   input  wire logic                            i_mosi,
   input  wire logic                            i_regulation_disable_pair_a,
   input  wire logic                            i_regulation_disable_pair_b,
   input  wire logic                            i_feedback_select,
   input  wire vdm_status_t [NUM_DRV-1:0]       i_status,
   input  wire vdm_meas_t   [NUM_DRV-1:0]       i_meas,
   input  wire logic        [ADC_W-1:0]         i_analog1_result,
   output logic                                 o_miso,
   output logic                                 o_miso_oe,
   output logic             [NUM_DRV-1:0][PAY_W-1:0] o_drv_payload,
   output logic             [NUM_DRV-1:0]       o_drv_pwm_mode,
   output logic                                 o_analog1_request,
   output logic                                 o_frame_error
);

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   logic [NUM_DRV-1:0][PAY_W-1:0] payload_ff, nxt_payload;
   logic [NUM_DRV-1:0]            pwm_mode_ff, nxt_pwm_mode;
   logic                          fmsg_ff, nxt_fmsg;
   logic [4:0]                    last_id_ff, nxt_last_id;
   logic                          adc_req_ff, nxt_adc_req;
   vdm_frame_t                    reply_ff, nxt_reply;

   logic [FRAME_W-1:0]            rx_word;
   logic                          rx_done;
   logic                          rx_len_ok;
   logic                          rx_bad;
   logic [4:0]                    rx_id;
   vdm_sel_t                      rx_sel;
   vdm_sel_t                      last_sel;
   logic [NUM_DRV-1:0][PAY_W-1:0] field;

   // driver two sits on pair a, three and four on pair b
   function automatic logic pair_disable(input logic [1:0] idx,
                                         input logic       dis_a,
                                         input logic       dis_b);
      return (idx == 2'h0) ? dis_a : dis_b;
   endfunction : pair_disable

   // ------------------------------------------------------------------------
   // serial frame shifter
   // ------------------------------------------------------------------------
   vdm_spi_shift u_shift (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_cs_n      (i_cs_n),
      .i_sclk      (i_sclk),
      .i_mosi      (i_mosi),
      .i_tx_word   (reply_ff),
      .o_miso      (o_miso),
      .o_miso_oe   (o_miso_oe),
      .o_rx_word   (rx_word),
      .o_rx_done   (rx_done),
      .o_rx_len_ok (rx_len_ok)
   );

   // ------------------------------------------------------------------------
   // readback selection per driver
   // ------------------------------------------------------------------------
   for (genvar g = 0; g < NUM_DRV; g++) begin : g_rb
      vdm_readback u_rb (
         .i_reg_disable     (pair_disable(2'(g), i_regulation_disable_pair_a,
                                          i_regulation_disable_pair_b)),
         .i_feedback_select (i_feedback_select),
         .i_payload         (payload_ff[g]),
         .i_duty_applied    (i_meas[g].duty_applied),
         .i_current         (i_meas[g].current),
         .o_field           (field[g])
      );
   end

   // ------------------------------------------------------------------------
   // frame decode and write
   // ------------------------------------------------------------------------
   // a short or long frame counts as a parity fault: its id cannot be trusted
   assign rx_bad = !rx_len_ok || !parity_ok(rx_word);
   assign rx_id  = rx_word[14:10];
   assign rx_sel = drv_slot(rx_id);

   always_comb begin
      nxt_payload  = payload_ff;
      nxt_fmsg     = fmsg_ff;
      nxt_last_id  = last_id_ff;
      nxt_adc_req  = 1'h0;
      nxt_pwm_mode = {i_regulation_disable_pair_b, i_regulation_disable_pair_b,
                      i_regulation_disable_pair_a};
      if (rx_done) begin
         nxt_fmsg    = rx_bad;
         nxt_last_id = rx_bad ? ID_NONE : rx_id;
         if (!rx_bad && rx_sel.hit) begin
            if (pair_disable(rx_sel.idx, i_regulation_disable_pair_a,
                             i_regulation_disable_pair_b)) begin
               nxt_payload[rx_sel.idx] = {rx_word[PAY_W-1:2], 2'h0};
            end else begin
               nxt_payload[rx_sel.idx] = rx_word[PAY_W-1:0];
            end
         end
         nxt_adc_req = !rx_bad && (rx_id == ID_ADC1);
      end
   end

   // ------------------------------------------------------------------------
   // reply build, refreshed every cycle so fault flags stay live
   // ------------------------------------------------------------------------
   assign last_sel = drv_slot(last_id_ff);

   always_comb begin
      nxt_reply      = '0;
      nxt_reply.fmsg = fmsg_ff;
      if (last_sel.hit) begin
         // flags pass straight through; drain flag never gates anything
         nxt_reply.flags = i_status[last_sel.idx];
         nxt_reply.data  = field[last_sel.idx];
      end else if (last_id_ff == ID_ADC1) begin
         nxt_reply.data = i_analog1_result;
      end
      nxt_reply.parity = PARITY_ODD ^ (^nxt_reply[FRAME_W-2:0]);
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         payload_ff  <= {NUM_DRV{PAYLOAD_RST}};
         pwm_mode_ff <= '0;
         fmsg_ff     <= FMSG_RST;
         last_id_ff  <= ID_NONE;
         adc_req_ff  <= 1'h0;
         reply_ff    <= vdm_frame_t'({PARITY_ODD, 15'h0000});
      end else begin
         payload_ff  <= nxt_payload;
         pwm_mode_ff <= nxt_pwm_mode;
         fmsg_ff     <= nxt_fmsg;
         last_id_ff  <= nxt_last_id;
         adc_req_ff  <= nxt_adc_req;
         reply_ff    <= nxt_reply;
      end
   end

   assign o_drv_payload     = payload_ff;
   assign o_drv_pwm_mode    = pwm_mode_ff;
   assign o_analog1_request = adc_req_ff;
   assign o_frame_error     = fmsg_ff;

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge i_mclk);
   endclocking

   default disable iff (i_rst);

   a_fmsg_follows_parity: assert property (
      rx_done |-> ##2 (reply_ff.fmsg == $past(rx_bad, 2)))
      else $error("parity flag in reply does not match previous frame");

   a_target_written: assert property (
      (rx_done && !rx_bad && rx_id == ID_DRV2 && !i_regulation_disable_pair_a)
      |=> (payload_ff[0] == $past(rx_word[PAY_W-1:0])))
      else $error("current target not stored for driver two");

   a_duty_low_bits: assert property (
      (rx_done && !rx_bad && rx_id == ID_DRV3 && i_regulation_disable_pair_b)
      |=> (payload_ff[1][1:0] == 2'h0) && (payload_ff[1][9:2] == $past(rx_word[9:2])))
      else $error("duty not stored as eight bits for driver three");

   a_target_readback: assert property (
      (last_id_ff == ID_DRV2 && !i_regulation_disable_pair_a && !i_feedback_select)
      |=> (reply_ff.data == $past(payload_ff[0])))
      else $error("stored target not echoed for driver two");

   a_applied_duty_back: assert property (
      (last_id_ff == ID_DRV4 && !i_regulation_disable_pair_b && i_feedback_select)
      |=> (reply_ff.data == {$past(i_meas[2].duty_applied), 2'h0}))
      else $error("applied duty not returned for driver four");

   a_duty_echo_zero: assert property (
      (last_id_ff == ID_DRV3 && i_regulation_disable_pair_b && !i_feedback_select)
      |=> (reply_ff.data[1:0] == 2'h0))
      else $error("duty echo low bits not forced to zero");

   a_current_readback: assert property (
      (last_id_ff == ID_DRV4 && i_regulation_disable_pair_b && i_feedback_select)
      |=> (reply_ff.data == $past(i_meas[2].current)))
      else $error("measured current not returned for driver four");

   a_fault_flags: assert property (
      (last_id_ff == ID_DRV3) |=> (reply_ff.flags == $past(i_status[1])))
      else $error("fault flags do not follow driver three status");

   a_pair_b_shared: assert property (
      (rx_done && !rx_bad && rx_id == ID_DRV4 && i_regulation_disable_pair_b
       && !i_regulation_disable_pair_a) |=> (payload_ff[2][1:0] == 2'h0))
      else $error("driver four did not follow pair b mode");

   a_adc_request: assert property (
      (rx_done && !rx_bad && rx_id == ID_ADC1) |=> o_analog1_request ##1 !o_analog1_request)
      else $error("analog request pulse missing or too long");

   a_adc_reply: assert property (
      (last_id_ff == ID_ADC1) |=> (reply_ff.data == $past(i_analog1_result))
      && (reply_ff.flags == '0))
      else $error("analog result not returned");

   a_reply_parity: assert property (
      ##1 parity_ok(reply_ff))
      else $error("reply parity wrong");

   // ------------------------------------------------------------------------
   // refusal and per driver checks
   // ------------------------------------------------------------------------
   // refused frames must leave every payload and request untouched
   // each cell of the readback table is watched on at least one driver
   a_fmsg_hold: assert property (
      !rx_done |=> (fmsg_ff == $past(fmsg_ff)))
      else $error("frame error flag moved without a frame");

   a_fmsg_clear: assert property (
      (rx_done && !rx_bad) |=> !fmsg_ff)
      else $error("frame error flag not cleared by good frame");

   a_len_refused: assert property (
      (rx_done && !rx_len_ok) |=> fmsg_ff)
      else $error("frame of wrong length not flagged");

   a_reply_fmsg_live: assert property (
      !i_rst |=> (reply_ff.fmsg == $past(fmsg_ff)))
      else $error("reply parity flag lags the frame error flag");

   a_bad_no_write: assert property (
      (rx_done && rx_bad) |=> (payload_ff == $past(payload_ff)))
      else $error("refused frame changed a payload");

   a_bad_no_request: assert property (
      (rx_done && rx_bad) |=> !o_analog1_request)
      else $error("refused frame raised an analog request");

   a_adc_no_write: assert property (
      (rx_done && rx_id == ID_ADC1) |=> (payload_ff == $past(payload_ff)))
      else $error("analog request changed a payload");

   a_target_drv3: assert property (
      (rx_done && !rx_bad && rx_id == ID_DRV3 && !i_regulation_disable_pair_b)
      |=> (payload_ff[1] == $past(rx_word[PAY_W-1:0])))
      else $error("current target not stored for driver three");

   a_target_drv4: assert property (
      (rx_done && !rx_bad && rx_id == ID_DRV4 && !i_regulation_disable_pair_b)
      |=> (payload_ff[2] == $past(rx_word[PAY_W-1:0])))
      else $error("current target not stored for driver four");

   a_duty_drv2: assert property (
      (rx_done && !rx_bad && rx_id == ID_DRV2 && i_regulation_disable_pair_a)
      |=> (payload_ff[0] == {$past(rx_word[PAY_W-1:2]), 2'h0}))
      else $error("duty not stored as eight bits for driver two");

   a_target_rb_drv3: assert property (
      (last_id_ff == ID_DRV3 && !i_regulation_disable_pair_b && !i_feedback_select)
      |=> (reply_ff.data == $past(payload_ff[1])))
      else $error("stored target not echoed for driver three");

   a_duty_back_drv2: assert property (
      (last_id_ff == ID_DRV2 && !i_regulation_disable_pair_a && i_feedback_select)
      |=> (reply_ff.data == {$past(i_meas[0].duty_applied), 2'h0}))
      else $error("applied duty not returned for driver two");

   a_duty_echo_drv2: assert property (
      (last_id_ff == ID_DRV2 && i_regulation_disable_pair_a && !i_feedback_select)
      |=> (reply_ff.data == {$past(payload_ff[0][PAY_W-1:2]), 2'h0}))
      else $error("programmed duty not echoed for driver two");

   a_current_drv2: assert property (
      (last_id_ff == ID_DRV2 && i_regulation_disable_pair_a && i_feedback_select)
      |=> (reply_ff.data == $past(i_meas[0].current)))
      else $error("measured current not returned for driver two");

   a_flags_drv2: assert property (
      (last_id_ff == ID_DRV2) |=> (reply_ff.flags == $past(i_status[0])))
      else $error("fault flags do not follow driver two status");

   a_flags_drv4: assert property (
      (last_id_ff == ID_DRV4) |=> (reply_ff.flags == $past(i_status[2])))
      else $error("fault flags do not follow driver four status");

   a_mode_copy: assert property (
      !i_rst |=> (o_drv_pwm_mode == {$past(i_regulation_disable_pair_b),
                                     $past(i_regulation_disable_pair_b), $past(i_regulation_disable_pair_a)}))
      else $error("driver mode bits do not follow their pair");

   a_unknown_silent: assert property (
      (!last_sel.hit && last_id_ff != ID_ADC1)
      |=> (reply_ff.data == '0) && (reply_ff.flags == '0))
      else $error("unknown identifier returned data or flags");

endmodule : vdm_top

// ===== verification/vdm_host_model.sv
// host side serial master model for the valve driver message block
module vdm_host_model
   import vdm_pkg::*;
(
   input  wire logic i_mclk,
   input  wire logic i_miso,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_mosi
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_cs_n = 1'h1;
      o_sclk = 1'h0;
      o_mosi = 1'h0;
   end

   // ----------------------------------------------------------------------
   // one frame, msb first; nbits below sixteen makes a short frame
   // ----------------------------------------------------------------------
   task automatic xfer(input logic [FRAME_W-1:0] w, input int nbits, output logic [FRAME_W-1:0] r);
      r = '0;
      repeat (2) @(posedge i_mclk);
      o_cs_n <= 1'h0;
      repeat (3) @(posedge i_mclk);
      for (int i = FRAME_W - 1; i >= FRAME_W - nbits; i--) begin
         o_mosi <= w[i];
         // long low phase: reply bit must have settled after the fall
         repeat (4) @(posedge i_mclk);
         o_sclk <= 1'h1;
         r[i]    = i_miso;
         repeat (2) @(posedge i_mclk);
         o_sclk <= 1'h0;
      end
      repeat (4) @(posedge i_mclk);
      o_cs_n <= 1'h1;
      // released line must not keep showing the last bit
      o_mosi <= ~o_mosi;
      repeat (6) @(posedge i_mclk);
   endtask : xfer

endmodule : vdm_host_model

// ===== verification/tb_top.sv
// self-checking bench for the valve driver message block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import vdm_pkg::*;

   logic                           mclk, rst, cs_n, sclk, mosi, miso, miso_oe;
   logic                           dis_a, dis_b, fb_sel, adc_req, frame_err;
   vdm_status_t [NUM_DRV-1:0]      status;
   vdm_meas_t   [NUM_DRV-1:0]      meas;
   logic [ADC_W-1:0]               adc;
   logic [NUM_DRV-1:0][PAY_W-1:0]  drv_payload;
   logic [NUM_DRV-1:0]             pwm_mode;
   logic [PAY_W-1:0]               exp_pay [NUM_DRV];
   logic [4:0]                     last_id;
   logic                           last_err;
   int                             n_errors, compares, n_req, n_req_exp, n_oe_bad;

   vdm_top i_vdm_top (.i_mclk(mclk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
      .i_regulation_disable_pair_a(dis_a), .i_regulation_disable_pair_b(dis_b),
      .i_feedback_select(fb_sel), .i_status(status), .i_meas(meas), .i_analog1_result(adc),
      .o_miso(miso), .o_miso_oe(miso_oe), .o_drv_payload(drv_payload), .o_drv_pwm_mode(pwm_mode),
      .o_analog1_request(adc_req), .o_frame_error(frame_err));

   vdm_host_model i_vdm_host_model (.i_mclk(mclk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));

   always #5 mclk = ~mclk;

   always @(posedge mclk) begin
      if (adc_req === 1'h1) n_req++;
      if (sclk === 1'h1 && miso_oe !== 1'h1) n_oe_bad++;
   end

   // ----------------------------------------------------------------------
   // checking and verdict
   // ----------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   function automatic logic [FRAME_W-1:0] exp_reply();
      logic [14:0] b;
      int          k;
      logic        dis;
      b     = '0;
      b[14] = last_err;
      k     = -1;
      case (last_id)
         ID_DRV2: k = 0;
         ID_DRV3: k = 1;
         ID_DRV4: k = 2;
         ID_ADC1: b[9:0] = adc;
         default: ;
      endcase
      if (k >= 0) begin
         dis       = (k == 0) ? dis_a : dis_b;
         b[13:10]  = status[k];
         case ({dis, fb_sel})
            2'h0:    b[9:0] = exp_pay[k];
            2'h1:    b[9:0] = {meas[k].duty_applied, 2'h0};
            2'h2:    b[9:0] = {exp_pay[k][9:2], 2'h0};
            default: b[9:0] = meas[k].current;
         endcase
      end
      return {~^b, b};
   endfunction : exp_reply

   // duty limited to what a host may program
   function automatic logic [7:0] pick_duty();
      int s;
      s = $urandom_range(3, 0);
      return (s == 0) ? 8'h00 : (s == 1) ? 8'hFF : 8'($urandom_range(229, 26));
   endfunction : pick_duty

   // bad: 0 good, 1 wrong parity, 2 fifteen bits
   task automatic frame(input logic [4:0] id, input logic [9:0] pay, input int bad);
      logic [15:0] w, r, e;
      int          nb, k;
      w     = {1'h0, id, pay};
      w[15] = ~^w[14:0];
      if (bad == 1) w[15] = ~w[15];
      nb = (bad == 2) ? 15 : 16;
      e  = exp_reply();
      i_vdm_host_model.xfer(w, nb, r);
      if (nb == 16) check(r, e, "reply word");
      last_err = (bad != 0);
      last_id  = (bad != 0) ? ID_NONE : id;
      k = (id == ID_DRV2) ? 0 : (id == ID_DRV3) ? 1 : (id == ID_DRV4) ? 2 : -1;
      if (bad == 0 && k >= 0)
         exp_pay[k] = (((k == 0) ? dis_a : dis_b) == 1'h1) ? {pay[9:2], 2'h0} : pay;
      if (bad == 0 && id == ID_ADC1) n_req_exp++;
      check(16'(frame_err), 16'(last_err), "frame error");
      for (int j = 0; j < NUM_DRV; j++) check(16'(drv_payload[j]), 16'(exp_pay[j]), "payload");
      check(16'(pwm_mode), 16'({dis_b, dis_b, dis_a}), "pwm mode");
      check(16'(n_req), 16'(n_req_exp), "analog requests");
   endtask : frame

   // ----------------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------------
   initial begin
      #500us;
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end

   initial begin
      logic [4:0] id;
      logic [9:0] pay;
      int         op;
      mclk = 1'h0; rst = 1'h1; dis_a = 1'h0; dis_b = 1'h0; fb_sel = 1'h0;
      status = '0; meas = '0; adc = '0;
      n_errors = 0; compares = 0; n_req = 0; n_req_exp = 0; n_oe_bad = 0;
      for (int j = 0; j < NUM_DRV; j++) exp_pay[j] = '0;
      last_id = ID_NONE; last_err = 1'h0;
      void'($urandom(61));
      repeat (6) @(posedge mclk);
      check(16'(drv_payload[0]), 16'h0000, "payload in reset");
      check(16'({miso_oe, frame_err, adc_req}), 16'h0000, "outputs in reset");
      rst <= 1'h0;
      repeat (4) @(posedge mclk);
      $display("test reset done");

      status <= $bits(status)'(12'hA5C);
      meas   <= $bits(meas)'({$urandom, $urandom});
      adc    <= 10'h2AA;
      @(posedge mclk);
      frame(ID_DRV2, 10'h3FF, 0);
      frame(ID_DRV3, 10'h000, 0);
      frame(ID_DRV4, 10'h155, 0);
      frame(ID_DRV2, 10'h001, 1);
      frame(ID_ADC1, 10'h000, 0);
      frame(ID_DRV3, 10'h0F0, 2);
      frame(ID_ADC1, 10'h000, 0);
      frame(5'h10, 10'h000, 0);
      frame(ID_DRV4, 10'h000, 0);
      $display("test corners done");

      for (int n = 0; n < 60; n++) begin
         @(posedge mclk);
         dis_a  <= 1'($urandom);
         dis_b  <= 1'($urandom);
         fb_sel <= 1'($urandom);
         status <= $bits(status)'($urandom);
         meas   <= $bits(meas)'({$urandom, $urandom});
         adc    <= 10'($urandom);
         @(posedge mclk);
         op  = $urandom_range(6, 0);
         id  = (op == 0) ? ID_DRV2 : (op == 1) ? ID_DRV3 : (op == 2) ? ID_DRV4 : (op == 3) ? ID_ADC1 : 5'h1F;
         if (op > 4) id = ID_DRV2 + 5'($urandom_range(2, 0));
         pay = 10'($urandom);
         if (op < 3 && ((op == 0) ? dis_a : dis_b) == 1'h1) pay = {pick_duty(), 2'($urandom)};
         if (op == 3) pay = 10'h000;
         frame(id, pay, (op > 4) ? op - 4 : 0);
      end
      frame(5'h1F, 10'h000, 0);
      $display("test random done");
      check(16'(n_oe_bad), 16'h0000, "output enable in frame");
      give_verdict();
   end

endmodule : tb_top
